// ### rtl/tpc_edge_sync.sv
`timescale 1ns/1ps
module tpc_edge_sync
	import tpc_pkg::*;
(
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic pin_i,
	input wire logic rise_sel_i,
	output logic edge_o
);
	logic s1_r;
	logic s2_r;
	logic s3_r;

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end
		else
		begin
			s1_r <= pin_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// chosen transition of the synchronised input
	assign edge_o = rise_sel_i ? (s2_r & ~s3_r) : (~s2_r & s3_r);

	AST_EDGE_DIR: assert property (@(posedge clk_i) disable iff (srst_i)
		edge_o |-> (s2_r == rise_sel_i))
		else $error("edge direction wrong");
endmodule

// ### rtl/tpc_params.svh
`ifndef TPC_PARAMS_SVH
`define TPC_PARAMS_SVH
// register byte offsets
`define TPC_OFF_CNT_HI 12'h000
`define TPC_OFF_CNT_LO 12'h004
`define TPC_OFF_RLD_HI 12'h008
`define TPC_OFF_RLD_LO 12'h00c
`define TPC_OFF_PWM_HI 12'h010
`define TPC_OFF_PWM_LO 12'h014
`define TPC_OFF_CTL0 12'h018
`define TPC_OFF_CTL1 12'h01c
`define TPC_OFF_CTL2 12'h020
`define TPC_OFF_IRQ_STA 12'h024
`define TPC_OFF_IRQ_MSK 12'h028
// reset values
`define TPC_RST_CNT 16'h0001
`define TPC_RST_RLD 16'hffff
// control 1 fields
`define TPC_CTL1_EN 7
`define TPC_CTL1_POL 6
`define TPC_CTL1_PRES_LSB 3
`define TPC_CTL1_MODE_LSB 0
// control 0 fields
`define TPC_CTL0_CAUSE 0
`define TPC_CTL0_CFG_LSB 6
// control 2 field
`define TPC_CTL2_SRC 0
// status / mask bits
`define TPC_IRQ_CAP 0
`define TPC_IRQ_RLD 1
// mode codes
`define TPC_MODE_PWM 4'h3
`define TPC_MODE_CAP 4'h4
`endif

// ### rtl/tpc_pkg.sv
package tpc_pkg;
	typedef enum logic [1:0] {TPC_IDLE, TPC_RUN} tpc_state_type;
	typedef logic [15:0] tpc_count_type;
endpackage

// ### rtl/tpc_prescaler.sv
`timescale 1ns/1ps
`include "tpc_params.svh"
module tpc_prescaler
	import tpc_pkg::*;
(
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic run_i,
	input wire logic src_tick_i,
	input wire logic [2:0] pres_i,
	output logic tick_o
);
	logic [6:0] div_r;
	logic [6:0] lim;

	assign lim = 7'((8'h01 << pres_i) - 8'h01);

	// divide source ticks by 2^pres
	always_ff @(posedge clk_i)
	begin
		if (srst_i || !run_i)
		begin
			div_r <= 7'h00;
			tick_o <= 1'b0;
		end
		else
		begin
			tick_o <= 1'b0;
			if (src_tick_i)
			begin
				if (div_r >= lim)
				begin
					div_r <= 7'h00;
					tick_o <= 1'b1;
				end
				else
					div_r <= div_r + 7'h01;
			end
		end
	end

	AST_PRES_ONE: assert property (@(posedge clk_i) disable iff (srst_i)
		(run_i && pres_i == 3'h0 && src_tick_i && $past(run_i)) |=> tick_o)
		else $error("prescale 1 missed tick");
endmodule

// ### rtl/tpc_timer.sv
`timescale 1ns/1ps
`include "tpc_params.svh"
module tpc_timer
	import tpc_pkg::*;
(
	input wire logic CLK_I,
	input wire logic SRST_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [11:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	input wire logic TIN_I,
	input wire logic EXT_CLK_I,
	output logic TOUT_O,
	output logic IRQ_O
);
	// ****************************************
	// registers
	// ****************************************
	tpc_count_type cnt_r;
	tpc_count_type rld_r;
	tpc_count_type pwm_r;
	logic [7:0] ctl0_r;
	logic [7:0] ctl1_r;
	logic [7:0] ctl2_r;
	logic [1:0] sta_r;
	logic [1:0] msk_r;
	logic first_r;
	tpc_state_type state_r;

	logic wr_en;
	logic rd_en;
	logic tick;
	logic cap_edge;
	logic src_tick;
	logic ext_s1_r;
	logic ext_s2_r;
	logic ext_s3_r;
	logic cap_ev;
	logic rld_ev;
	logic enabled;
	logic [3:0] operating_mode_field;
	logic polarity_edge_select;
	logic [1:0] irq_config_field;
	logic pwm_hit;
	assign enabled = ctl1_r[`TPC_CTL1_EN];
	assign polarity_edge_select = ctl1_r[`TPC_CTL1_POL];
	assign operating_mode_field = ctl1_r[`TPC_CTL1_MODE_LSB +: 4];
	assign irq_config_field = ctl0_r[`TPC_CTL0_CFG_LSB +: 2];
	function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
		hit = (a == off);
	endfunction
	// ****************************************
	// apb slave
	// ****************************************
	assign wr_en = PSEL_I && PENABLE_I && PWRITE_I;
	assign rd_en = PSEL_I && !PWRITE_I && !PENABLE_I;

	always_ff @(posedge CLK_I)
	begin
		if (SRST_I)
		begin
			PREADY_O <= 1'b0;
			PSLVERR_O <= 1'b0;
			PRDATA_O <= 32'h0000_0000;
		end
		else
		begin
			PREADY_O <= PSEL_I && !PENABLE_I;
			PSLVERR_O <= 1'b0;
			if (rd_en)
			begin
				PRDATA_O <= 32'h0000_0000;
				if (hit(PADDR_I, `TPC_OFF_CNT_HI))
					PRDATA_O <= {24'h000000, cnt_r[15:8]};
				if (hit(PADDR_I, `TPC_OFF_CNT_LO))
					PRDATA_O <= {24'h000000, cnt_r[7:0]};
				if (hit(PADDR_I, `TPC_OFF_RLD_HI))
					PRDATA_O <= {24'h000000, rld_r[15:8]};
				if (hit(PADDR_I, `TPC_OFF_RLD_LO))
					PRDATA_O <= {24'h000000, rld_r[7:0]};
				if (hit(PADDR_I, `TPC_OFF_PWM_HI))
					PRDATA_O <= {24'h000000, pwm_r[15:8]};
				if (hit(PADDR_I, `TPC_OFF_PWM_LO))
					PRDATA_O <= {24'h000000, pwm_r[7:0]};
				if (hit(PADDR_I, `TPC_OFF_CTL0))
					PRDATA_O <= {24'h000000, ctl0_r};
				if (hit(PADDR_I, `TPC_OFF_CTL1))
					PRDATA_O <= {24'h000000, ctl1_r};
				if (hit(PADDR_I, `TPC_OFF_CTL2))
					PRDATA_O <= {24'h000000, ctl2_r};
				if (hit(PADDR_I, `TPC_OFF_IRQ_STA))
					PRDATA_O <= {30'h00000000, sta_r};
				if (hit(PADDR_I, `TPC_OFF_IRQ_MSK))
					PRDATA_O <= {30'h00000000, msk_r};
			end
		end
	end

	// ****************************************
	// control registers
	// ****************************************
	always_ff @(posedge CLK_I)
	begin
		if (SRST_I)
		begin
			ctl1_r <= 8'h00;
			ctl2_r <= 8'h00;
			rld_r <= `TPC_RST_RLD;
			msk_r <= 2'h0;
		end
		else if (wr_en && PREADY_O)
		begin
			if (hit(PADDR_I, `TPC_OFF_CTL1))
				ctl1_r <= PWDATA_I[7:0];
			if (hit(PADDR_I, `TPC_OFF_CTL2))
				ctl2_r <= PWDATA_I[7:0];
			if (hit(PADDR_I, `TPC_OFF_RLD_HI))
				rld_r[15:8] <= PWDATA_I[7:0];
			if (hit(PADDR_I, `TPC_OFF_RLD_LO))
				rld_r[7:0] <= PWDATA_I[7:0];
			if (hit(PADDR_I, `TPC_OFF_IRQ_MSK))
				msk_r <= PWDATA_I[1:0];
		end
	end

	// ****************************************
	// clock source and capture input
	// ****************************************
	always_ff @(posedge CLK_I)
	begin
		if (SRST_I)
		begin
			ext_s1_r <= 1'b0;
			ext_s2_r <= 1'b0;
			ext_s3_r <= 1'b0;
		end
		else
		begin
			ext_s1_r <= EXT_CLK_I;
			ext_s2_r <= ext_s1_r;
			ext_s3_r <= ext_s2_r;
		end
	end
	// source 0 is system clock, source 1 external rising edges
	assign src_tick = ctl2_r[`TPC_CTL2_SRC] ? (ext_s2_r & ~ext_s3_r) : 1'b1;

	tpc_prescaler u_pres (
		.clk_i(CLK_I),
		.srst_i(SRST_I),
		.run_i(enabled),
		.src_tick_i(src_tick),
		.pres_i(ctl1_r[`TPC_CTL1_PRES_LSB +: 3]),
		.tick_o(tick)
	);

	tpc_edge_sync u_edge (
		.clk_i(CLK_I),
		.srst_i(SRST_I),
		.pin_i(TIN_I),
		.rise_sel_i(polarity_edge_select),
		.edge_o(cap_edge)
	);

	assign cap_ev = enabled && operating_mode_field == `TPC_MODE_CAP && cap_edge;
	assign rld_ev = enabled && tick && cnt_r == rld_r;

	// ****************************************
	// counter
	// ****************************************
	always_ff @(posedge CLK_I)
	begin
		if (SRST_I)
		begin
			cnt_r <= `TPC_RST_CNT;
			state_r <= TPC_IDLE;
		end
		else
		begin
			case (state_r)
				TPC_IDLE:
				begin
					if (enabled)
						state_r <= TPC_RUN;
				end
				TPC_RUN:
				begin
					if (!enabled)
						state_r <= TPC_IDLE;
				end
				default:
					state_r <= TPC_IDLE;
			endcase
			if (wr_en && PREADY_O && hit(PADDR_I, `TPC_OFF_CNT_HI))
				cnt_r[15:8] <= PWDATA_I[7:0];
			else if (wr_en && PREADY_O && hit(PADDR_I, `TPC_OFF_CNT_LO))
				cnt_r[7:0] <= PWDATA_I[7:0];
			else if (rld_ev)
				cnt_r <= 16'h0001;
			else if (enabled && tick)
				cnt_r <= cnt_r + 16'h0001;
		end
	end

	// ****************************************
	// capture, cause flag and pwm value
	// ****************************************
	always_ff @(posedge CLK_I)
	begin
		if (SRST_I)
		begin
			pwm_r <= 16'h0000;
			ctl0_r <= 8'h00;
		end
		else
		begin
			if (cap_ev)
				pwm_r <= cnt_r;
			else if (wr_en && PREADY_O && hit(PADDR_I, `TPC_OFF_PWM_HI))
				pwm_r[15:8] <= PWDATA_I[7:0];
			else if (wr_en && PREADY_O && hit(PADDR_I, `TPC_OFF_PWM_LO))
				pwm_r[7:0] <= PWDATA_I[7:0];
			if (wr_en && PREADY_O && hit(PADDR_I, `TPC_OFF_CTL0))
				ctl0_r[7:1] <= PWDATA_I[7:1];
			if (cap_ev)
				ctl0_r[`TPC_CTL0_CAUSE] <= 1'b1;
			else if (rld_ev && operating_mode_field == `TPC_MODE_CAP)
				ctl0_r[`TPC_CTL0_CAUSE] <= 1'b0;
		end
	end

	// ****************************************
	// interrupt status
	// ****************************************
	always_ff @(posedge CLK_I)
	begin
		if (SRST_I)
		begin
			sta_r <= 2'h0;
			IRQ_O <= 1'b0;
		end
		else
		begin
			// set wins over write-one-to-clear
			sta_r <= (sta_r & ~((wr_en && PREADY_O && hit(PADDR_I, `TPC_OFF_IRQ_STA))
				? PWDATA_I[1:0] : 2'h0)) | {rld_ev, cap_ev};
			IRQ_O <= |(sta_r & msk_r);
		end
	end

	// ****************************************
	// pwm output
	// ****************************************
	// first period counts from the loaded start like a one-shot
	always_ff @(posedge CLK_I)
	begin
		if (SRST_I)
			first_r <= 1'b1;
		else if (!enabled)
			first_r <= 1'b1;
		else if (rld_ev)
			first_r <= 1'b0;
	end

	assign pwm_hit = cnt_r > pwm_r;
	always_ff @(posedge CLK_I)
	begin
		if (SRST_I)
			TOUT_O <= 1'b0;
		else if (!enabled || operating_mode_field != `TPC_MODE_PWM)
			TOUT_O <= polarity_edge_select;
		else if (first_r && cnt_r <= pwm_r)
			TOUT_O <= polarity_edge_select;
		else if (polarity_edge_select)
			TOUT_O <= !pwm_hit;
		else
			TOUT_O <= pwm_hit;
	end

	// ****************************************
	// checks
	// ****************************************
	AST_CAP_LATCH: assert property (@(posedge CLK_I) disable iff (SRST_I)
		cap_ev |=> pwm_r == $past(cnt_r))
		else $error("capture value not stored");
	AST_CAP_FLAG: assert property (@(posedge CLK_I) disable iff (SRST_I)
		cap_ev |=> ctl0_r[`TPC_CTL0_CAUSE] && sta_r[`TPC_IRQ_CAP])
		else $error("capture flag not set");
	AST_RLD_CLR: assert property (@(posedge CLK_I) disable iff (SRST_I)
		(rld_ev && !cap_ev && operating_mode_field == `TPC_MODE_CAP)
		|=> !ctl0_r[`TPC_CTL0_CAUSE] && sta_r[`TPC_IRQ_RLD])
		else $error("reload cause not cleared");
	AST_RLD_WRAP: assert property (@(posedge CLK_I) disable iff (SRST_I)
		(rld_ev && !wr_en) |=> cnt_r == 16'h0001)
		else $error("counter did not restart at one");
	AST_CAP_RUN: assert property (@(posedge CLK_I) disable iff (SRST_I)
		(cap_ev && tick && !rld_ev && !wr_en) |=> cnt_r == $past(cnt_r) + 16'h0001)
		else $error("counter stopped on capture");
	AST_IRQ_LVL: assert property (@(posedge CLK_I) disable iff (SRST_I)
		(sta_r & msk_r) != 2'h0 |=> IRQ_O)
		else $error("interrupt not raised");
	AST_PWM_POL1: assert property (@(posedge CLK_I) disable iff (SRST_I)
		(enabled && operating_mode_field == `TPC_MODE_PWM && !first_r && polarity_edge_select
		&& $stable(ctl1_r) && cnt_r > pwm_r) |=> !TOUT_O)
		else $error("pwm polarity one wrong");
	AST_PWM_POL0: assert property (@(posedge CLK_I) disable iff (SRST_I)
		(enabled && operating_mode_field == `TPC_MODE_PWM && !first_r && !polarity_edge_select
		&& $stable(ctl1_r) && cnt_r > pwm_r) |=> TOUT_O)
		else $error("pwm polarity zero wrong");
	AST_CNT_STEP: assert property (@(posedge CLK_I) disable iff (SRST_I)
		(!enabled && !wr_en) |=> $stable(cnt_r))
		else $error("counter moved while disabled");
	AST_ONESHOT: assert property (@(posedge CLK_I) disable iff (SRST_I)
		(enabled && operating_mode_field == `TPC_MODE_PWM && first_r && cnt_r <= pwm_r
		&& $stable(ctl1_r)) |=> TOUT_O == polarity_edge_select)
		else $error("first period not one-shot");
endmodule

// ### tb/tpc_pin_model.sv
`timescale 1ns/1ps
module tpc_pin_model
(
	input wire logic clk_i,
	output logic tin_o,
	output logic ext_clk_o
);
	// ****************************************
	// far-side pins: capture input and count source
	// ****************************************
	initial
	begin
		tin_o = 1'b0;
		ext_clk_o = 1'b0;
	end
	// count source stands low between bursts, eight system cycles a period
	task automatic clock_edges(input int n);
		repeat (n)
		begin
			@(posedge clk_i);
			ext_clk_o <= 1'b1;
			repeat (4) @(posedge clk_i);
			ext_clk_o <= 1'b0;
			repeat (3) @(posedge clk_i);
		end
		repeat (6) @(posedge clk_i);
	endtask
	// level held long enough for the input synchroniser
	task automatic set_pin(input logic v);
		@(posedge clk_i);
		tin_o <= v;
		repeat (8) @(posedge clk_i);
	endtask
endmodule

// ### tb/tpc_timer_bench.sv
`timescale 1ns/1ps
`include "tpc_params.svh"
module tpc_timer_bench;
	import tpc_pkg::*;
	logic clk, srst, psel, penable, pwrite, pready, pslverr, tin, ext_clk, tout, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [31:0] exp_q[$];
	int err_total, cmp_count, n, hi;
	tpc_timer dut_u (.CLK_I(clk), .SRST_I(srst), .PSEL_I(psel), .PENABLE_I(penable),
		.PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
		.PREADY_O(pready), .PSLVERR_O(pslverr), .TIN_I(tin), .EXT_CLK_I(ext_clk),
		.TOUT_O(tout), .IRQ_O(irq));
	tpc_pin_model pin_u (.clk_i(clk), .tin_o(tin), .ext_clk_o(ext_clk));
	// ****************************************
	// helpers
	// ****************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		cmp_count++;
		if (seen !== want)
		begin
			err_total++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, want);
		end
	endtask
	task automatic print_verdict;
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int t;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		t = 0;
		do
		begin
			@(posedge clk);
			t++;
		end
		while (pready !== 1'b1 && t < 50);
		if (t >= 50)
			err_total++;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		xfer(1'b1, a, {24'($urandom()), d});
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] want);
		exp_q.push_back({24'h0, want});
		xfer(1'b0, a, $urandom());
	endtask
	task automatic chk_irq(input logic want);
		repeat (2) @(posedge clk);
		@(negedge clk);
		check({31'h0, irq}, {31'h0, want});
		@(posedge clk);
	endtask
	// read data taken at the completing edge, checked against the oldest note
	always @(posedge clk)
		if (psel && penable && pready === 1'b1)
		begin
			check({31'h0, pslverr}, 32'h0);
			if (!pwrite)
				check(prdata, exp_q.pop_front());
		end
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial
	begin
		repeat (20000) @(posedge clk);
		err_total++;
		print_verdict();
	end
	// ****************************************
	// scenarios
	// ****************************************
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		srst = 1'b1;
		err_total = 0;
		cmp_count = 0;
		n = $urandom(32'h10810642);
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		rd(`TPC_OFF_CNT_LO, 8'h01);
		rd(`TPC_OFF_RLD_HI, 8'hff);
		rd(12'h0fc, 8'h00);
		wr(`TPC_OFF_CTL1, 8'h44);
		wr(`TPC_OFF_CTL2, 8'h01);
		wr(`TPC_OFF_CTL0, 8'h40);
		wr(`TPC_OFF_CNT_HI, 8'h00);
		wr(`TPC_OFF_CNT_LO, 8'h01);
		wr(`TPC_OFF_RLD_HI, 8'h00);
		wr(`TPC_OFF_RLD_LO, 8'h20);
		wr(`TPC_OFF_IRQ_MSK, 8'h02);
		wr(`TPC_OFF_CTL1, 8'hc4);
		n = 1 + $urandom_range(20);
		pin_u.clock_edges(n);
		pin_u.set_pin(1'b1);
		chk_irq(1'b0);
		rd(`TPC_OFF_IRQ_STA, 8'h01);
		rd(`TPC_OFF_CTL0, 8'h41);
		rd(`TPC_OFF_PWM_HI, 8'h00);
		rd(`TPC_OFF_PWM_LO, 8'(1 + n));
		pin_u.clock_edges(2);
		rd(`TPC_OFF_CNT_LO, 8'(3 + n));
		wr(`TPC_OFF_IRQ_MSK, 8'h03);
		chk_irq(1'b1);
		wr(`TPC_OFF_IRQ_STA, 8'h01);
		chk_irq(1'b0);
		// falling edge selected: rising must be ignored
		wr(`TPC_OFF_CTL1, 8'h84);
		pin_u.set_pin(1'b0);
		rd(`TPC_OFF_IRQ_STA, 8'h01);
		wr(`TPC_OFF_IRQ_STA, 8'h01);
		pin_u.clock_edges(1);
		pin_u.set_pin(1'b1);
		rd(`TPC_OFF_IRQ_STA, 8'h00);
		rd(`TPC_OFF_PWM_LO, 8'(3 + n));
		pin_u.clock_edges(29 - n);
		rd(`TPC_OFF_CNT_LO, 8'h01);
		rd(`TPC_OFF_IRQ_STA, 8'h02);
		rd(`TPC_OFF_CTL0, 8'h40);
		chk_irq(1'b1);
		wr(`TPC_OFF_IRQ_STA, 8'h03);
		// prescale field 010 divides by four
		wr(`TPC_OFF_CTL1, 8'h14);
		wr(`TPC_OFF_CNT_LO, 8'h01);
		wr(`TPC_OFF_CTL1, 8'h94);
		pin_u.clock_edges(8);
		rd(`TPC_OFF_CNT_LO, 8'h03);
		// duty over ten whole periods of reload 8, pwm 2
		wr(`TPC_OFF_CTL2, 8'h00);
		wr(`TPC_OFF_RLD_LO, 8'h08);
		wr(`TPC_OFF_PWM_LO, 8'h02);
		for (int p = 0; p < 2; p++)
		begin
			wr(`TPC_OFF_CTL1, 8'h03);
			wr(`TPC_OFF_CNT_LO, 8'h01);
			wr(`TPC_OFF_CTL1, 8'h83 | 8'(p << 6));
			repeat (16) @(posedge clk);
			hi = 0;
			repeat (80)
			begin
				@(negedge clk);
				hi += (tout === 1'b1);
			end
			check(hi, p ? 20 : 60);
			@(posedge clk);
		end
		print_verdict();
	end
endmodule
